// ### dac_load_override_clear_cmd_bench.sv
// Bench for the load-override / clear-code block.
// Assumes the host model drives the serial link.
`timescale 1ns/100ps
`default_nettype none
module dac_load_override_clear_cmd_bench;
    logic core_clk, reset_n, load_strobe_n, clear_strobe_n, serial_clk, frame_sel_n, serial_din;
    logic [3:0] chan_update, load_override_mask;
    logic [1:0] clear_code_select;
    dlo_pkg::dlo_clear_s clear_event;
    int mismatches, tests_run;
    dlo_cmd u_dut (.core_clk, .reset_n, .serial_clk, .frame_sel_n, .serial_din, .load_strobe_n,
        .clear_strobe_n, .chan_update, .clear_event, .load_override_mask, .clear_code_select);
    dlo_host_model u_host (.serial_clk, .frame_sel_n, .serial_din);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Hang guard: the tests need about 54 us, so 400 us is ample
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    // Mask set, strobe low, mask cleared, then refused frames
    task automatic t_override();
        u_host.send_frame(32'hF6A5_5A35, 32);
        check(16'(load_override_mask), 16'h0005);
        check(16'(chan_update), 16'h0005);
        @(posedge core_clk) #1 load_strobe_n = 1'b0;
        repeat (9) @(posedge core_clk);
        #1 check(16'(chan_update), 16'h000F);
        load_strobe_n = 1'b1;
        u_host.send_frame(32'h0600_0000, 32);
        check(16'(chan_update), 16'h0000);
        u_host.send_frame(32'h0600_000F, 31);
        check(16'(load_override_mask), 16'h0000);
        u_host.send_frame(32'h0700_000F, 32);
        check(16'(load_override_mask), 16'h0000);
    endtask : t_override
    // Every clear selection, each followed by a clear pulse
    task automatic t_clear();
        logic seen;
        for (int s = 0; s < 4; s++) begin
            u_host.send_frame(32'hA5F0_FFFC | 32'(s), 32);
            check(16'(clear_code_select), 16'(s));
            seen = 1'b0;
            @(posedge core_clk) #1 clear_strobe_n = 1'b0;
            repeat (20) begin
                @(posedge core_clk) #1;
                if (clear_event.valid === 1'b1) begin
                    seen = 1'b1;
                    check(clear_event.code, s == 0 ? 16'h0 : s == 1 ? 16'h8000 : 16'hFFFF);
                end
            end
            clear_strobe_n = 1'b1;
            check(16'(seen), 16'(s != 3));
        end
    endtask : t_clear
    // Clear in mid-frame kills the write; the next frame still lands
    task automatic t_abort();
        fork
            u_host.send_frame(32'h0600_000F, 32);
            begin
                repeat (100) @(posedge core_clk);
                #1 clear_strobe_n = 1'b0;
                repeat (30) @(posedge core_clk);
                #1 clear_strobe_n = 1'b1;
            end
        join
        check(16'(load_override_mask), 16'h0000);
        u_host.send_frame(32'h0600_0003, 32);
        check(16'(load_override_mask), 16'h0003);
    endtask : t_abort
    // Reset in mid-run returns both registers and the enables to zero
    task automatic t_reset();
        @(posedge core_clk) #1 reset_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 reset_n = 1'b1;
        repeat (5) @(posedge core_clk);
        #1 check(16'(load_override_mask), 16'h0000);
        check(16'(clear_code_select), 16'h0000);
        check(16'(chan_update), 16'h0000);
        u_host.send_frame(32'h0600_0009, 32);
        check(16'(load_override_mask), 16'h0009);
        check(16'(chan_update), 16'h0009);
    endtask : t_reset
    initial begin
        mismatches = 0;
        tests_run = 0;
        reset_n = 1'b0;
        load_strobe_n = 1'b1;
        clear_strobe_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 reset_n = 1'b1;
        repeat (5) @(posedge core_clk);
        #1 check(16'(load_override_mask), 16'h0000);
        t_override();
        t_clear();
        t_abort();
        t_reset();
        summarize();
    end
endmodule : dac_load_override_clear_cmd_bench
`default_nettype wire

// ### dlo_cmd.sv
// Serial command interpreter for load-override and clear-code registers.
// Assumes a host that drives serial clock, frame select and data; the
// serial clock may stop between frames. Core logic runs on core_clk.
// Commands other than load-override and clear-code leave both registers alone.
`timescale 1ns/100ps
`default_nettype none
module dlo_cmd #(
    parameter int unsigned CH = dlo_pkg::CHANNELS
) (
    // Core clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    // Serial link from host
    input  wire logic                 serial_clk,
    input  wire logic                 frame_sel_n,
    input  wire logic                 serial_din,
    // Hardware strobes
    input  wire logic                 load_strobe_n,
    input  wire logic                 clear_strobe_n,
    // Per-channel update enables towards DAC registers
    output logic [CH-1:0]             chan_update,
    // Clear event to input and DAC registers
    output dlo_pkg::dlo_clear_s       clear_event,
    // Register contents for observation
    output logic [CH-1:0]             load_override_mask,
    output logic [1:0]                clear_code_select
);

    // Block is built for exactly four channels
    if (CH != dlo_pkg::CHANNELS) begin : g_bad_ch
        $error("dlo_cmd supports four channels only");
    end

    // ---------------- Link domain ----------------
    // Edge counts for the last bit of a frame and for a full frame
    localparam logic [5:0] LAST_EDGE = 6'(dlo_pkg::FRAME_BITS - 1);
    localparam logic [5:0] FULL_EDGE = 6'(dlo_pkg::FRAME_BITS);

    logic [30:0] shift_q;     // Bits received so far
    logic [5:0]  count_q;     // Falling edges seen, stops at a full frame
    logic [31:0] frame_q;     // Last complete frame
    logic        done_tgl_q;  // Toggles per completed frame
    logic        link_clr;    // Select high or core reset clears the link state

    // Core reset joins select so the counter never starts out unknown
    assign link_clr = frame_sel_n | ~reset_n;

    // Shift in on falling edge; select high resets the shift state
    always_ff @(negedge serial_clk or posedge link_clr) begin
        if (link_clr) begin
            // Frame cut short: partial bits are thrown away
            shift_q <= 31'h0000_0000;
            count_q <= 6'h00;
        end else begin
            // Next bit, most significant first
            shift_q <= {shift_q[29:0], serial_din};
            if (count_q != FULL_EDGE) begin
                // Edges past the 32nd are ignored until select goes high
                count_q <= 6'(count_q + 6'h01);
            end
        end
    end

    // Capture on the 32nd edge and flag by toggle; frame held stable
    always_ff @(negedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_q    <= 32'h0000_0000;
            done_tgl_q <= 1'b0;
        end else if (!frame_sel_n && count_q == LAST_EDGE) begin
            frame_q    <= {shift_q, serial_din};
            done_tgl_q <= ~done_tgl_q;
        end
    end

    // ---------------- Core domain ----------------
    logic done_lvl;       // Synchronised toggle
    logic done_prev_q;    // Toggle level one cycle back
    logic load_lvl;       // Synchronised load strobe
    logic clr_lvl;        // Synchronised clear strobe
    logic clr_prev_q;     // Clear level one cycle back
    logic frame_sel_lvl;  // Synchronised frame select

    // Frame-done toggle; resets to the toggle's own reset value
    dlo_sync #(.RESET_VAL(1'b0)) u_done (
        .clk      (core_clk),
        .reset_n  (reset_n),
        .pin_in   (done_tgl_q),
        .level_out(done_lvl)
    );
    // Load strobe pin, idles high
    dlo_sync #(.RESET_VAL(1'b1)) u_load (
        .clk      (core_clk),
        .reset_n  (reset_n),
        .pin_in   (load_strobe_n),
        .level_out(load_lvl)
    );
    // Clear pin, idles high so reset gives no false edge
    dlo_sync #(.RESET_VAL(1'b1)) u_clr (
        .clk      (core_clk),
        .reset_n  (reset_n),
        .pin_in   (clear_strobe_n),
        .level_out(clr_lvl)
    );
    // Frame select, used only for the abort window
    dlo_sync #(.RESET_VAL(1'b1)) u_sel (
        .clk      (core_clk),
        .reset_n  (reset_n),
        .pin_in   (frame_sel_n),
        .level_out(frame_sel_lvl)
    );

    logic frame_done;   // One-cycle pulse per completed frame
    logic clr_fall;     // One-cycle pulse on clear falling edge
    logic aborted_q;    // Clear seen while this frame was selected
    dlo_pkg::dlo_frame_s fr;

    assign frame_done = done_lvl ^ done_prev_q;
    assign clr_fall   = clr_prev_q & ~clr_lvl;
    // Fields of the captured frame; it settles long before frame_done,
    // so no further crossing logic is needed to read it here
    assign fr.command_nibble        = frame_q[dlo_pkg::CMD_MSB:dlo_pkg::CMD_LSB];
    assign fr.channel_select_nibble = frame_q[dlo_pkg::ADDR_MSB:dlo_pkg::ADDR_LSB];
    assign fr.clear_code_bits       = frame_q[1:0];
    assign fr.override_bits         = frame_q[3:0];

    // Edge history; clear history resets high, the idle pin level,
    // so no false clear edge follows reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Match the synchroniser reset values
            done_prev_q <= 1'b0;
            clr_prev_q  <= 1'b1;
        end else begin
            done_prev_q <= done_lvl;
            clr_prev_q  <= clr_lvl;
        end
    end

    // Clear during a selected frame aborts that frame's effect
    // Select is seen through its synchroniser, so the window lags the pin
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aborted_q <= 1'b0;
        end else if (clr_fall && !frame_sel_lvl) begin
            // Set wins over the release below
            aborted_q <= 1'b1;
        end else if (frame_sel_lvl && !frame_done) begin
            // Select back high: the next frame starts clean
            aborted_q <= 1'b0;
        end
    end

    // True when the captured frame carries the given command code
    function automatic logic is_cmd(input dlo_pkg::dlo_frame_s f, input logic [3:0] code);
        return f.command_nibble == code;
    endfunction : is_cmd

    // A frame counts only if complete and not hit by a clear
    logic frame_accept;
    assign frame_accept = frame_done & ~aborted_q & ~clr_fall;

    // Override register: written by a load-override frame only
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Strobe pin in charge of every channel after reset
            load_override_mask <= dlo_pkg::OVR_RESET;
        end else if (frame_accept && is_cmd(fr, dlo_pkg::CMD_LOAD_OVR)) begin
            // Address and middle bits play no part
            load_override_mask <= fr.override_bits;
        end
    end

    // Clear code register: written by a clear-code frame only
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clear_code_select <= dlo_pkg::CLR_SEL_RESET;
        end else if (frame_accept && is_cmd(fr, dlo_pkg::CMD_CLR_CODE)) begin
            clear_code_select <= fr.clear_code_bits;
        end
    end

    // Update enable: override forces strobe low per channel
    // Level output: stands while the strobe or the override stands
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_update <= '0;
        end else begin
            for (int i = 0; i < CH; i++) begin
                // Bit 1 overrides pin, bit 0 follows pin
                chan_update[i] <= load_override_mask[i] | ~load_lvl;
            end
        end
    end

    // Map selection to clear code
    function automatic dlo_pkg::dlo_clear_s clear_map(input logic [1:0] sel);
        dlo_pkg::dlo_clear_s r;
        r.valid = 1'b1;
        r.code  = dlo_pkg::CODE_ZERO;
        unique case (sel)
            dlo_pkg::CLR_SEL_ZERO: r.code = dlo_pkg::CODE_ZERO;
            dlo_pkg::CLR_SEL_MID:  r.code = dlo_pkg::CODE_MID;
            dlo_pkg::CLR_SEL_FULL: r.code = dlo_pkg::CODE_FULL;
            default:               r.valid = 1'b0;  // Selection 11 does nothing
        endcase
        return r;
    endfunction : clear_map

    // Clear event pulse with selected code
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clear_event <= '0;
        end else if (clr_fall) begin
            // One pulse per clear edge unless the register holds 11, code from the register
            clear_event <= clear_map(clear_code_select);
        end else begin
            // Code held, only the pulse drops
            clear_event.valid <= 1'b0;
        end
    end

endmodule : dlo_cmd
`default_nettype wire

// ### dlo_cmd_assertions.sv
// Assertions on the command block's core ports.
// Assumes one core clock domain, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module dlo_cmd_assertions (
    // Clock, reset, pins
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic load_strobe_n,
    input wire logic clear_strobe_n,
    // Outputs watched
    input wire logic [3:0] chan_update,
    input wire dlo_pkg::dlo_clear_s clear_event,
    input wire logic [3:0] load_override_mask,
    input wire logic [1:0] clear_code_select
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Pin levels held long enough to cross the synchroniser
    sequence s_low; !load_strobe_n [*8]; endsequence
    sequence s_high; load_strobe_n [*8]; endsequence
    sequence s_keep; $stable(load_override_mask) [*3]; endsequence
    a_mask_reset: assert property ($rose(reset_n) |-> !load_override_mask)
        else $error("mask reset");
    a_strobe_low: assert property (s_low |-> chan_update == 4'hF)
        else $error("strobe low");
    a_strobe_high: assert property (s_high ##0 s_keep |-> chan_update == load_override_mask)
        else $error("strobe high");
    a_clear_map: assert property (clear_event.valid |-> clear_code_select != 2'h3 &&
        clear_event.code == (clear_code_select[1] ? 16'hFFFF : {clear_code_select[0], 15'h0}))
        else $error("clear code");
    a_clear_fall: assert property ($fell(clear_strobe_n) && clear_code_select != 2'h3
        |-> ##[3:8] clear_event.valid) else $error("no clear");
    a_clear_once: assert property (clear_event.valid |=> !clear_event.valid)
        else $error("long clear");
    a_clear_cause: assert property (clear_event.valid |-> !$past(clear_strobe_n, 3))
        else $error("stray clear");
    a_mask_holds: assert property ($changed(load_override_mask) |=> s_keep)
        else $error("mask churn");
endmodule : dlo_cmd_assertions
bind dlo_cmd dlo_cmd_assertions u_chk (.core_clk, .reset_n, .load_strobe_n, .clear_strobe_n,
    .chan_update, .clear_event, .load_override_mask, .clear_code_select);
`default_nettype wire

// ### dlo_host_model.sv
// Host serial port: clock idles low, MSB first, byte bursts.
// Assumes the block samples data on falling clock edges.
`timescale 1ns/100ps
`default_nettype none
module dlo_host_model (
    // Link to the block
    output logic serial_clk,
    output logic frame_sel_n,
    output logic serial_din
);
    initial begin
        serial_clk = 1'b0;
        frame_sel_n = 1'b1;
        serial_din = 1'b0;
    end
    // Under 32 bits cuts the frame short
    task automatic send_frame(input logic [31:0] word, input int nbits);
        #33.3 frame_sel_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            if (i % 8 == 0) #125;
            serial_clk = 1'b1;
            serial_din = word[31-i];
            #62.5 serial_clk = 1'b0;
            #62.5;
        end
        frame_sel_n = 1'b1;
        serial_din = ~serial_din; // No stale bit once released
        #250;
    endtask : send_frame
endmodule : dlo_host_model
`default_nettype wire

// ### dlo_pkg.sv
// Constants and carrier types for the load-override / clear-code command block.
// Assumes a 32-bit serial frame, MSB first, four DAC channels of 16 bits.
// Overview of operation
// - Override bit 0: channel follows load strobe pin
// - Override bit 1: channel updates as strobe low
// - Frame bits 3..0 map channels D..A
// - Command 0110 loads override; other fields ignored
// - Command 0101 loads clear code from bits 1..0
// - Data bits sampled on serial clock falling edge
// - Zero bits return channel to hardware strobe
// - Clear code: 0000, 8000, FFFF, or no operation
// - Early frame select release discards the frame
// - Clear falling edge loads code, aborts write
// - Override bits reset to zero
package dlo_pkg;

    localparam int unsigned FRAME_BITS     = 32;
    localparam int unsigned CHANNELS       = 4;
    localparam int unsigned CODE_BITS      = 16;
    // Command field position inside the frame
    localparam int unsigned CMD_LSB        = 24;
    localparam int unsigned CMD_MSB        = 27;
    localparam int unsigned ADDR_LSB       = 20;
    localparam int unsigned ADDR_MSB       = 23;
    // Command codes
    localparam logic [3:0]  CMD_LOAD_OVR   = 4'h6;
    localparam logic [3:0]  CMD_CLR_CODE   = 4'h5;
    // Clear code selections and codes
    localparam logic [1:0]  CLR_SEL_ZERO   = 2'h0;
    localparam logic [1:0]  CLR_SEL_MID    = 2'h1;
    localparam logic [1:0]  CLR_SEL_FULL   = 2'h2;
    localparam logic [15:0] CODE_ZERO      = 16'h0000;
    localparam logic [15:0] CODE_MID       = 16'h8000;
    localparam logic [15:0] CODE_FULL      = 16'hFFFF;
    // Reset values
    localparam logic [3:0]  OVR_RESET      = 4'h0;
    localparam logic [1:0]  CLR_SEL_RESET  = 2'h0;

    // Frame delivered from the link domain
    typedef struct packed {
        logic [3:0] command_nibble;
        logic [3:0] channel_select_nibble;
        logic [1:0] clear_code_bits;
        logic [3:0] override_bits;
    } dlo_frame_s;

    // Clear event output: code and its validity
    typedef struct packed {
        logic        valid;
        logic [15:0] code;
    } dlo_clear_s;

endpackage : dlo_pkg

// ### dlo_sync.sv
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module dlo_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Raw pin and filtered level
    input  wire logic pin_in,
    output logic      level_out
);

    logic s1_q;   // Metastability catcher, read only by s2
    logic s2_q;   // Second stage
    logic s3_q;   // Third stage

    // Shift chain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Level changes only when the last two stages agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_out <= RESET_VAL;
        end else if (s2_q == s3_q) begin
            level_out <= s3_q;
        end
    end

endmodule : dlo_sync
`default_nettype wire
